/* File: hw/nvs_host_ctrl.sv */
// Purpose: host controller driving an asynchronous nonvolatile sram by its strobes
// Assumes: one request at a time, device pins sampled as synchronous inputs
// Notes:   timing held to the fastest speed grade, so only that grade is served
// Summary of operation
// RQ1: write strobe high on reads, low writing
// RQ2: nonvolatile strobe high during ram cycles
// RQ3: read keeps selected, device drives addressed byte
// RQ4: write before select keeps device data off
// RQ5: device releases data after write strobe falls
// RQ6: device drives no sooner than after write
// RQ7: select held low long enough before write end
// RQ8: device enters standby after select rises
// RQ9: hold store state; store self-completes within limit
// RQ10: store initiation ended by any strobe
// RQ11: device refuses store under low supply
// RQ12: avoid recall state when storing
// RQ13: output strobe high before nonvolatile falls
// RQ14: device recalls automatically at power-up; boot leaves after one enabled edge without waiting for it
// RQ15: store state: select, write, nonvolatile low
// RQ16: device ignores inputs during store
// RQ17: recall state: select, output, nonvolatile low
// RQ18: standby delayed while nonvolatile op runs
// RQ19: write whenever select and write strobe low
// RQ20: no-operation combinations change nothing
`timescale 1ns/10ps
module nvs_host_ctrl (
  input  wire logic                     ref_clk,
  input  wire logic                     sys_rst,
  input  wire logic                     clk_en,
  input  wire logic                     req_valid,
  output logic                          req_ready,
  input  wire nvs_pkg::nvs_cmd_t        req_cmd,
  input  wire logic [nvs_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [nvs_pkg::DATA_W-1:0] req_wdata,
  output logic                          rsp_valid,
  output logic [nvs_pkg::DATA_W-1:0]    rsp_rdata,
  output logic                          busy,
  output logic [nvs_pkg::ADDR_W-1:0]    address_bus,
  output logic                          chip_sel_n,
  output logic                          write_en_n,
  output logic                          out_en_n,
  output logic                          nonvolatile_select_n,
  input  wire logic [nvs_pkg::DATA_W-1:0] data_bus_i,
  output logic [nvs_pkg::DATA_W-1:0]    data_bus_o,
  output logic                          data_bus_oe
);
  nvs_pkg::nvs_state_t          st_reg, st_next;         // sequencer state
  logic [nvs_pkg::ADDR_W-1:0]   addr_reg, addr_next;     // latched address
  logic [nvs_pkg::DATA_W-1:0]   wd_reg, wd_next;         // write data
  logic [nvs_pkg::DATA_W-1:0]   rd_reg, rd_next;         // captured read byte
  logic                         rv_reg, rv_next;         // read answer pulse
  logic                         ce_reg, ce_next;         // select strobe, low active
  logic                         we_reg, we_next;         // write strobe
  logic                         oe_reg, oe_next;         // output strobe
  logic                         nv_reg, nv_next;         // nonvolatile strobe
  logic                         doe_reg, doe_next;       // we drive the data pins
  logic                         tm_load;                 // timer reload
  logic [nvs_pkg::CNT_W-1:0]    tm_val;                  // timer reload value
  logic                         tm_done;                 // timer expired

  // one timer for every strobe width and busy wait
  nvs_wait_timer u_timer (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .load     (tm_load),
    .load_val (tm_val),
    .done     (tm_done)
  );

  // sequencer next state and strobe levels
  always_comb begin
    st_next   = st_reg;
    addr_next = addr_reg;
    wd_next   = wd_reg;
    rd_next   = rd_reg;
    rv_next   = 1'b0;
    ce_next   = ce_reg;
    we_next   = we_reg;
    oe_next   = oe_reg;
    nv_next   = nv_reg;
    doe_next  = doe_reg;
    tm_load   = 1'b0;
    tm_val    = '0;
    case (st_reg)
      nvs_pkg::NVS_ST_BOOT: begin
        // leave after one enabled edge without awaiting the power-up recall, all strobes idle
        if (tm_done) begin // RQ14
          st_next = nvs_pkg::NVS_ST_IDLE;
        end
      end
      nvs_pkg::NVS_ST_IDLE: begin
        // all strobes high: standby, no transfer starts
        if (req_valid) begin // RQ20
          addr_next = req_addr;
          wd_next   = req_wdata;
          tm_load   = 1'b1;
          case (req_cmd)
            nvs_pkg::NVS_CMD_READ: begin
              // write strobe stays high, output enabled
              ce_next = 1'b0; // RQ1 RQ2 RQ3
              oe_next = 1'b0;
              tm_val  = nvs_pkg::CNT_W'(nvs_pkg::READ_CYC);
              st_next = nvs_pkg::NVS_ST_READ;
            end
            nvs_pkg::NVS_CMD_WRITE: begin
              // write strobe falls with select so device never drives
              ce_next  = 1'b0; // RQ4 RQ19
              we_next  = 1'b0; // RQ1
              doe_next = 1'b1;
              tm_val   = nvs_pkg::CNT_W'(nvs_pkg::WRITE_CYC);
              st_next  = nvs_pkg::NVS_ST_WRITE;
            end
            nvs_pkg::NVS_CMD_STORE: begin
              // output stays high so the recall state never appears
              ce_next = 1'b0; // RQ15 RQ12 RQ13
              we_next = 1'b0;
              nv_next = 1'b0;
              tm_val  = nvs_pkg::CNT_W'(nvs_pkg::INIT_CYC);
              st_next = nvs_pkg::NVS_ST_INIT;
            end
            default: begin
              // recall: write strobe stays high so no store is started
              ce_next = 1'b0; // RQ17
              oe_next = 1'b0;
              nv_next = 1'b0;
              tm_val  = nvs_pkg::CNT_W'(nvs_pkg::INIT_CYC);
              st_next = nvs_pkg::NVS_ST_INIT;
            end
          endcase
        end
      end
      nvs_pkg::NVS_ST_READ: begin
        // sample once the read cycle time has elapsed
        if (tm_done) begin // RQ3
          rd_next = data_bus_i;
          rv_next = 1'b1;
          ce_next = 1'b1; // RQ8
          oe_next = 1'b1;
          st_next = nvs_pkg::NVS_ST_IDLE;
        end
      end
      nvs_pkg::NVS_ST_WRITE: begin
        // select and write pulse both held the full width
        if (tm_done) begin // RQ7
          ce_next = 1'b1;
          we_next = 1'b1;
          tm_load = 1'b1;
          tm_val  = nvs_pkg::CNT_W'(nvs_pkg::RELEASE_CYC);
          st_next = nvs_pkg::NVS_ST_REL;
        end
      end
      nvs_pkg::NVS_ST_REL: begin
        // data held one cycle past the write end, then a turnaround gap before the next cycle
        doe_next = 1'b0; // RQ6
        if (tm_done) begin
          st_next = nvs_pkg::NVS_ST_IDLE;
        end
      end
      nvs_pkg::NVS_ST_INIT: begin
        // initiation held, then end it by raising nonvolatile strobe
        if (tm_done) begin // RQ9
          nv_next = 1'b1; // RQ10
          ce_next = 1'b1;
          we_next = 1'b1;
          oe_next = 1'b1;
          tm_load = 1'b1;
          tm_val  = we_reg ? nvs_pkg::CNT_W'(nvs_pkg::RECALL_CYC)
                           : nvs_pkg::CNT_W'(nvs_pkg::STORE_CYC);
          st_next = nvs_pkg::NVS_ST_NVWAIT;
        end
      end
      nvs_pkg::NVS_ST_NVWAIT: begin
        // device ignores pins until the transfer is over
        if (tm_done) begin // RQ16 RQ18 RQ11
          st_next = nvs_pkg::NVS_ST_IDLE;
        end
      end
      default: begin
        st_next = nvs_pkg::NVS_ST_IDLE;
      end
    endcase
  end

  // registers only; boot wait starts from the reset value
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_reg   <= nvs_pkg::NVS_ST_BOOT;
      addr_reg <= '0;
      wd_reg   <= '0;
      rd_reg   <= '0;
      rv_reg   <= 1'b0;
      ce_reg   <= 1'b1;
      we_reg   <= 1'b1;
      oe_reg   <= 1'b1;
      nv_reg   <= 1'b1;
      doe_reg  <= 1'b0;
    end else if (clk_en) begin
      st_reg   <= st_next;
      addr_reg <= addr_next;
      wd_reg   <= wd_next;
      rd_reg   <= rd_next;
      rv_reg   <= rv_next;
      ce_reg   <= ce_next;
      we_reg   <= we_next;
      oe_reg   <= oe_next;
      nv_reg   <= nv_next;
      doe_reg  <= doe_next;
    end
  end

  // boot lasts one enabled edge; the power-up recall wait is left to the system,
  // which must hold reset or requests off until the device has restored
  assign req_ready            = (st_reg == nvs_pkg::NVS_ST_IDLE);
  assign busy                 = !req_ready;
  assign rsp_valid            = rv_reg;
  assign rsp_rdata            = rd_reg;
  assign address_bus          = addr_reg;
  assign chip_sel_n           = ce_reg;
  assign write_en_n           = we_reg;
  assign out_en_n             = oe_reg;
  assign nonvolatile_select_n = nv_reg;
  assign data_bus_o           = wd_reg;
  assign data_bus_oe          = doe_reg;
endmodule

/* File: hw/nvs_pkg.sv */
// Purpose: shared constants for the nonvolatile sram host controller
// Assumes: 100 MHz ref_clk, fastest speed grade timing
// Notes:   times in ns, us or ms, cycle counts derived from the clock period
package nvs_pkg;
  localparam int CLK_PERIOD_NS = 10;                     // ref_clk period
  localparam int ADDR_W        = 11;                     // 2k bytes
  localparam int DATA_W        = 8;                      // byte wide
  // least times round up
  localparam int READ_CYCLE_NS    = 25;                  // read cycle time
  localparam int WRITE_PULSE_NS   = 20;                  // strobe low to end of write
  localparam int ADDR_SETUP_NS    = 0;                   // address set-up to write start
  localparam int INIT_HOLD_NS     = 20;                  // initiation_hold_time
  localparam int WR_RELEASE_NS    = 15;                  // write_output_release_delay, slowest
  localparam int STORE_MS         = 10;                  // store completes within
  localparam int RECALL_US        = 20;                  // recall completes within
  localparam int RESTORE_US       = 550;                 // power-up recall duration
  localparam int READ_CYC    = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYC   = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_CYC    = (INIT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RELEASE_CYC = (WR_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STORE_CYC   = STORE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int RECALL_CYC  = RECALL_US * 1000 / CLK_PERIOD_NS;
  localparam int RESTORE_CYC = RESTORE_US * 1000 / CLK_PERIOD_NS;
  localparam int CNT_W       = 24;                       // wait counter width
  // command codes on the user side
  typedef enum logic [1:0] {
    NVS_CMD_READ   = 2'h0,
    NVS_CMD_WRITE  = 2'h1,
    NVS_CMD_STORE  = 2'h2,
    NVS_CMD_RECALL = 2'h3
  } nvs_cmd_t;
  // one-hot sequencer states
  typedef enum logic [6:0] {
    NVS_ST_BOOT   = 7'h01,
    NVS_ST_IDLE   = 7'h02,
    NVS_ST_READ   = 7'h04,
    NVS_ST_WRITE  = 7'h08,
    NVS_ST_REL    = 7'h10,
    NVS_ST_INIT   = 7'h20,
    NVS_ST_NVWAIT = 7'h40
  } nvs_state_t;
endpackage

/* File: hw/nvs_wait_timer.sv */
// Purpose: loadable down counter for strobe and busy timing
// Assumes: load has priority over counting
// Notes:   done is high while the count is zero
`timescale 1ns/10ps
module nvs_wait_timer (
  input  wire logic                    ref_clk,
  input  wire logic                    sys_rst,
  input  wire logic                    clk_en,
  input  wire logic                    load,
  input  wire logic [nvs_pkg::CNT_W-1:0] load_val,
  output logic                         done
);
  logic [nvs_pkg::CNT_W-1:0] cnt_reg;  // remaining cycles
  logic [nvs_pkg::CNT_W-1:0] cnt_next; // next count

  // reload or count down to zero
  always_comb begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next = load_val;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  // register only, frozen when clock enable is low
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_reg <= '0;
    end else if (clk_en) begin
      cnt_reg <= cnt_next;
    end
  end

  assign done = (cnt_reg == '0);
endmodule

/* File: test/nvs_host_ctrl_properties.sv */
// Purpose: strobe timing checks on the host controller pins
// Assumes: clk_en high across every launch and read; offsets follow the hand-over walk
// Notes:   windows of one cycle absorb the register stage at launch
`timescale 1ns/10ps
module nvs_host_ctrl_properties (
  input wire logic              ref_clk,
  input wire logic              sys_rst,
  input wire logic              clk_en,
  input wire logic              req_valid,
  input wire logic              req_ready,
  input wire nvs_pkg::nvs_cmd_t req_cmd,
  input wire logic              rsp_valid,
  input wire logic              chip_sel_n,
  input wire logic              write_en_n,
  input wire logic              out_en_n,
  input wire logic              nonvolatile_select_n,
  input wire logic              data_bus_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // accepted request of each kind
  wire logic tk = req_valid && req_ready && clk_en;
  wire logic tk_rd = tk && req_cmd == nvs_pkg::NVS_CMD_READ;
  wire logic tk_wr = tk && req_cmd == nvs_pkg::NVS_CMD_WRITE;
  wire logic tk_st = tk && req_cmd == nvs_pkg::NVS_CMD_STORE;
  wire logic tk_rc = tk && req_cmd == nvs_pkg::NVS_CMD_RECALL;
  wire logic st_on = !chip_sel_n && !write_en_n && !nonvolatile_select_n;
  property p_rd_we; !chip_sel_n && !out_en_n && nonvolatile_select_n |-> write_en_n; endproperty
  a_rd_we: assert property (p_rd_we) else $error("write strobe low in read");
  property p_ram_nv; data_bus_oe |-> nonvolatile_select_n; endproperty
  a_ram_nv: assert property (p_ram_nv) else $error("nv strobe low in ram write");
  property p_wr_hold;
    $fell(chip_sel_n) && !write_en_n && nonvolatile_select_n |-> !chip_sel_n [*2];
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("select too short");
  property p_st_hold; $fell(nonvolatile_select_n) && !write_en_n |-> st_on [*2]; endproperty
  a_st_hold: assert property (p_st_hold) else $error("store state too short");
  property p_st_oe; !nonvolatile_select_n && !write_en_n |-> out_en_n; endproperty
  a_st_oe: assert property (p_st_oe) else $error("output strobe low in store");
  property p_rd_go; tk_rd |-> ##[1:2] (!chip_sel_n && !out_en_n); endproperty
  a_rd_go: assert property (p_rd_go) else $error("read strobes missing");
  property p_rd_rsp; tk_rd |-> ##5 rsp_valid; endproperty
  a_rd_rsp: assert property (p_rd_rsp) else $error("read answer late");
  property p_wr_go; tk_wr |-> ##[1:2] (!chip_sel_n && !write_en_n && data_bus_oe); endproperty
  a_wr_go: assert property (p_wr_go) else $error("write strobes missing");
  property p_st_go; tk_st |-> ##[1:2] (st_on && out_en_n); endproperty
  a_st_go: assert property (p_st_go) else $error("store state missing");
  property p_st_end; tk_st |-> ##[4:5] nonvolatile_select_n; endproperty
  a_st_end: assert property (p_st_end) else $error("store initiation not ended");
  property p_rc_go; tk_rc |-> ##[1:2] (!chip_sel_n && !out_en_n && !nonvolatile_select_n); endproperty
  a_rc_go: assert property (p_rc_go) else $error("recall state missing");
  c_rd: cover property (tk_rd);
  c_wr: cover property (tk_wr);
  c_rc: cover property (tk_rc);
  c_st: cover property (tk_st);
endmodule
bind nvs_host_ctrl nvs_host_ctrl_properties u_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .clk_en(clk_en), .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd),
  .rsp_valid(rsp_valid), .chip_sel_n(chip_sel_n), .write_en_n(write_en_n),
  .out_en_n(out_en_n), .nonvolatile_select_n(nonvolatile_select_n),
  .data_bus_oe(data_bus_oe));

/* File: test/nvs_sram_model.sv */
// Purpose: behavioural nonvolatile sram answering the host strobes
// Assumes: shortened store and recall times
// Notes:   released bus shows the inverse of its last value
`timescale 1ns/10ps
module nvs_sram_model #(
  parameter int STORE_NS  = 1000,
  parameter int RECALL_NS = 200,
  parameter bit SUPPLY_OK = 1'b1
) (
  input  wire logic       ce_n,
  input  wire logic       we_n,
  input  wire logic       oe_n,
  input  wire logic       nv_n,
  input  wire logic [10:0] addr,
  input  wire logic [7:0] host_d,
  input  wire logic       host_oe,
  output wire logic [7:0] bus
);
  logic [7:0] ram [2048];          // sram cells
  logic [7:0] nvc [2048];          // shadow cells
  logic       op_busy = 1'b0;      // nonvolatile op running, inputs ignored
  logic [7:0] last = 8'h00;        // last driven bus value
  wire logic  drv;                 // delayed output drive
  wire logic rd = !ce_n && !oe_n && we_n && nv_n && !op_busy;
  wire logic wr = !ce_n && !we_n && nv_n && !op_busy;
  wire logic st = !ce_n && !we_n && oe_n && !nv_n;
  wire logic rc = !ce_n && !oe_n && we_n && !nv_n;
  wire logic standby = ce_n && !op_busy;
  // 5 ns turn-on keeps data off right after a write, turn-off well inside the release
  assign #5 drv = rd;
  assign bus = host_oe ? host_d : (drv ? ram[addr] : ~last);
  always @(bus) if (host_oe || drv) last = bus;
  // power-up recall fills the sram from the shadow cells
  initial begin
    for (int i = 0; i < 2048; i++) begin
      nvc[i] = 8'(i * 3) ^ 8'h5A;
      ram[i] = nvc[i];
    end
  end
  // byte lands at the end of the write
  always @(negedge wr) ram[addr] = host_d;
  always @(posedge st) if (SUPPLY_OK && !op_busy) begin
    op_busy = 1'b1;
    nvc = ram;
    #(STORE_NS) op_busy = 1'b0;
  end
  always @(posedge rc) if (!op_busy) begin
    op_busy = 1'b1;
    ram = nvc;
    #(RECALL_NS) op_busy = 1'b0;
  end
endmodule

/* File: test/testbench.sv */
// Purpose: random write and read traffic, recall and store launch
// Assumes: clk_en high except for one frozen write
// Notes:   store completion is too long to await, so the run ends in it
`timescale 1ns/10ps
module testbench;
  logic ref_clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0;
  logic clk_en = 1'b1;               // freeze control
  nvs_pkg::nvs_cmd_t req_cmd = nvs_pkg::NVS_CMD_READ;
  logic [10:0] req_addr = 11'h000, a;
  logic [7:0]  req_wdata = 8'h00, rsp_rdata, data_bus_i, data_bus_o, exp_mem [2048];
  logic [10:0] address_bus;
  logic        req_ready, rsp_valid, busy, chip_sel_n, write_en_n, out_en_n;
  logic        nonvolatile_select_n, data_bus_oe;
  logic [31:0] rng = 32'h0001071D;   // fixed seed
  int          fails = 0, comparisons = 0, cyc = 0;
  always #5 ref_clk = ~ref_clk;
  nvs_host_ctrl dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd), .req_addr(req_addr),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .busy(busy),
    .address_bus(address_bus), .chip_sel_n(chip_sel_n), .write_en_n(write_en_n),
    .out_en_n(out_en_n), .nonvolatile_select_n(nonvolatile_select_n),
    .data_bus_i(data_bus_i), .data_bus_o(data_bus_o), .data_bus_oe(data_bus_oe));
  nvs_sram_model u_mem (.ce_n(chip_sel_n), .we_n(write_en_n), .oe_n(out_en_n),
    .nv_n(nonvolatile_select_n), .addr(address_bus), .host_d(data_bus_o),
    .host_oe(data_bus_oe), .bus(data_bus_i));
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  // shadow contents that the partner model starts with and recalls
  function automatic logic [7:0] nv_init(input int i);
    return 8'(i * 3) ^ 8'h5A;
  endfunction
  task automatic summarize();
    if (fails == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // raise a request after an edge, hold it until an edge samples ready high
  task automatic op(input nvs_pkg::nvs_cmd_t c, input logic [10:0] ad, input logic [7:0] d);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_cmd   <= c;
    req_addr  <= ad;
    req_wdata <= d;
    do @(posedge ref_clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
  endtask
  task automatic rd(input logic [10:0] ad);
    int n;
    n = 0;
    op(nvs_pkg::NVS_CMD_READ, ad, 8'h00);
    while (rsp_valid !== 1'b1 && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
    check({7'h00, rsp_valid}, 8'h01);
    check(rsp_rdata, exp_mem[ad]);
  endtask
  task automatic wr(input logic [10:0] ad, input logic [7:0] d);
    op(nvs_pkg::NVS_CMD_WRITE, ad, d);
    exp_mem[ad] = d;
  endtask
  // hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 10000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    for (int i = 0; i < 2048; i++) exp_mem[i] = nv_init(i);
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(11'h005);
    wr(11'h000, 8'hFF);
    wr(11'h7FF, 8'h00);
    rd(11'h000);
    rd(11'h7FF);
    for (int i = 0; i < 12; i++) begin
      a = 11'(xs());
      wr(a, 8'(xs()));
      rd(a);
    end
    // freeze mid write: strobes and timer hold, byte still lands
    wr(11'h123, 8'hA5);
    @(posedge ref_clk);
    clk_en <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check({7'h00, write_en_n}, 8'h00);
    clk_en <= 1'b1;
    rd(11'h123);
    op(nvs_pkg::NVS_CMD_RECALL, 11'h000, 8'h00);
    for (int i = 0; i < 2048; i++) exp_mem[i] = nv_init(i);
    rd(a);
    rd(11'h000);
    op(nvs_pkg::NVS_CMD_STORE, 11'h000, 8'h00);
    repeat (20) @(negedge ref_clk);
    check(busy, 1'b1);
    check(nonvolatile_select_n, 1'b1);
    summarize();
  end
endmodule
